// file: can_irq_flag_mask.sv
//
// Behaviour
// - unread flag sets whenever any unread status bit is set
// - unread flag clears only when all unread bits clear; writes ignored
// - mailbox-empty flag sets when a transmit-wait bit ends by completion or abort
// - mailbox-empty flag clears only on a write of one
// - 16-bit mailbox mask, resets to all ones, bytes swapped against mailbox number
// - mailbox mask bit zero lets that mailbox request through, one blocks it
// - transmit mailbox source is transmit-wait clearing at end or cancel
// - receive mailbox source is receive-complete bit rising at reception end
// - 16-bit source mask, writable bits reset to one; reset flag has none
// - bit 15 gates overload-frame flag onto the overrun line
// - bits 14, 13 gate bus-off and error-passive onto error status line
// - bits 12, 11, 10 gate rx warn, tx warn, remote request onto overrun line
// - bit 9 gates receive-message flag onto its own line
// - bit 4 gates the bus-activity flag onto the overrun line
// - bit 1 gates the unread flag onto the overrun line
// - bit 0 gates the mailbox-empty flag onto its own line
// - source mask bits 7..5, 3, 2 read one; software writes one
// - source mask bit 8 reads zero; software writes zero
// - receive-message flag sets on reception in a mailbox with mask zero
// - unread bit sets when a message arrives before receive-complete clears
// - reset flag sets after reset completes, unmaskable, cleared by writing one
//
// The APB slave port and the register addresses were chosen for this implementation.
`include "can_irq_defines.svh"

`default_nettype none

module can_irq_flag_mask (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // mailbox events from the transmit and receive logic, mailbox order
    input  wire logic [15:0] tx_end_evt,
    input  wire logic [15:0] rx_arrive,
    input  wire logic [15:0] receive_complete_bits,
    // status flags kept by the protocol engine
    input  wire logic        overload_frame_flag,
    input  wire logic        bus_off_flag,
    input  wire logic        error_passive_flag,
    input  wire logic        rx_overload_warn_flag,
    input  wire logic        tx_overload_warn_flag,
    input  wire logic        remote_request_flag,
    input  wire logic        bus_activity_set,
    input  wire logic        reset_done_set,
    // interrupt request lines and per-mailbox sources
    output logic             overrun_irq_line,
    output logic             error_status_irq_line,
    output logic             rx_message_irq_line,
    output logic             mailbox_empty_irq_line,
    output logic      [15:0] mailbox_src_evt
);

    can_irq_pkg::irq_state_type st_ff;
    can_irq_pkg::irq_state_type nxt_st;

    logic [15:0] rx_edge;
    logic [15:0] unread_status_bits;
    logic [15:0] unread_clr;
    logic [15:0] mask_mbx;
    logic [15:0] flag_view;
    logic [15:0] src_view;
    logic [31:0] rd_word;
    logic        rd_miss;
    logic        acc;
    logic        commit;
    logic        wr_flag;
    logic        wr_mbx;
    logic        wr_src;
    logic        wr_unread;

    // mailbox-order mask, shared with the tracker
    assign mask_mbx = can_irq_pkg::swap_bytes(st_ff.mbx_mask);

    // write strobes fire only at the edge where pready is seen high
    assign acc       = psel && penable;
    assign commit    = acc && (st_ff.phase == can_irq_pkg::PH_ACK);
    assign wr_flag   = commit && pwrite && (paddr == `OFS_FLAG);
    assign wr_mbx    = commit && pwrite && (paddr == `OFS_MBX_MASK);
    assign wr_src    = commit && pwrite && (paddr == `OFS_SRC_MASK);
    assign wr_unread = commit && pwrite && (paddr == `OFS_UNREAD);
    assign unread_clr = wr_unread ? can_irq_pkg::swap_bytes(pwdata[15:0]) : 16'h0000;

    can_mailbox_track u_track (
        .pclk                  (pclk),
        .presetn               (presetn),
        .ce                    (ce),
        .tx_end_evt            (tx_end_evt),
        .rx_arrive             (rx_arrive),
        .receive_complete_bits (receive_complete_bits),
        .mask_mbx              (mask_mbx),
        .unread_clr            (unread_clr),
        .rx_edge               (rx_edge),
        .unread_status_bits    (unread_status_bits),
        .mailbox_src_evt       (mailbox_src_evt)
    );

    // readable views of the flag register and the source mask
    always_comb begin
        flag_view                  = 16'h0000;
        flag_view[`FB_OVERLOAD]    = overload_frame_flag;
        flag_view[`FB_BUS_OFF]     = bus_off_flag;
        flag_view[`FB_ERR_PASSIVE] = error_passive_flag;
        flag_view[`FB_RX_WARN]     = rx_overload_warn_flag;
        flag_view[`FB_TX_WARN]     = tx_overload_warn_flag;
        flag_view[`FB_REMOTE_REQ]  = remote_request_flag;
        flag_view[`FB_RX_MSG]      = st_ff.rx_msg_flag;
        flag_view[`FB_RESET_DONE]  = st_ff.reset_done_flag;
        flag_view[`FB_BUS_ACT]     = st_ff.bus_act_flag;
        flag_view[`FB_UNREAD]      = st_ff.unread_flag;
        flag_view[`FB_MBX_EMPTY]   = st_ff.mbx_empty_flag;
        // reserved bits are not stored, so they cannot drift from their fixed value
        src_view = (st_ff.src_mask & `SRC_WR_BITS) | `SRC_ONE_BITS;
    end

    // read mux; unmapped addresses answer zero with an error
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_miss = 1'b0;
        unique case (paddr)
            `OFS_FLAG:     rd_word = {16'h0000, flag_view};
            `OFS_MBX_MASK: rd_word = {16'h0000, st_ff.mbx_mask};
            `OFS_SRC_MASK: rd_word = {16'h0000, src_view};
            `OFS_UNREAD:   rd_word = {16'h0000, can_irq_pkg::swap_bytes(unread_status_bits)};
            default:       rd_miss = 1'b1;
        endcase
    end

    // next state of the slave, the flags, the masks and the lines
    always_comb begin
        nxt_st = st_ff;

        // apb: first access cycle samples the answer, second one completes
        unique case (st_ff.phase)
            can_irq_pkg::PH_IDLE: begin
                if (acc) begin
                    nxt_st.phase   = can_irq_pkg::PH_ACK;
                    nxt_st.prdata  = pwrite ? 32'h0000_0000 : rd_word;
                    nxt_st.pslverr = rd_miss;
                end
            end
            can_irq_pkg::PH_ACK: begin
                nxt_st.phase = can_irq_pkg::PH_IDLE;
            end
            default: begin
                nxt_st.phase = can_irq_pkg::PH_IDLE;
            end
        endcase

        // masks; reserved source bits are dropped on write
        if (wr_mbx) begin
            nxt_st.mbx_mask = pwdata[15:0];
        end
        if (wr_src) begin
            nxt_st.src_mask = pwdata[15:0] & `SRC_WR_BITS;
        end

        // unread flag only mirrors the status bits, a write cannot touch it
        nxt_st.unread_flag = |unread_status_bits;

        // receive message flag; clears once every receive-complete bit is gone
        if (receive_complete_bits == 16'h0000) begin
            nxt_st.rx_msg_flag = 1'b0;
        end
        if (|(rx_edge & ~mask_mbx)) begin
            nxt_st.rx_msg_flag = 1'b1;
        end

        // write-one-to-clear flags; a set in the same cycle wins
        if (wr_flag && pwdata[`FB_MBX_EMPTY]) begin
            nxt_st.mbx_empty_flag = 1'b0;
        end
        if (|tx_end_evt) begin
            nxt_st.mbx_empty_flag = 1'b1;
        end
        if (wr_flag && pwdata[`FB_BUS_ACT]) begin
            nxt_st.bus_act_flag = 1'b0;
        end
        if (bus_activity_set) begin
            nxt_st.bus_act_flag = 1'b1;
        end
        if (wr_flag && pwdata[`FB_RESET_DONE]) begin
            nxt_st.reset_done_flag = 1'b0;
        end
        if (reset_done_set) begin
            nxt_st.reset_done_flag = 1'b1;
        end

        // request lines from current flags and masks, one clock behind a mask write
        nxt_st.ovr_line = (overload_frame_flag   && !st_ff.src_mask[`FB_OVERLOAD])
                       || (rx_overload_warn_flag && !st_ff.src_mask[`FB_RX_WARN])
                       || (tx_overload_warn_flag && !st_ff.src_mask[`FB_TX_WARN])
                       || (remote_request_flag   && !st_ff.src_mask[`FB_REMOTE_REQ])
                       || (st_ff.bus_act_flag    && !st_ff.src_mask[`FB_BUS_ACT])
                       || (st_ff.unread_flag     && !st_ff.src_mask[`FB_UNREAD])
                       || st_ff.reset_done_flag;
        nxt_st.ers_line = (bus_off_flag       && !st_ff.src_mask[`FB_BUS_OFF])
                       || (error_passive_flag && !st_ff.src_mask[`FB_ERR_PASSIVE]);
        nxt_st.rm_line  = st_ff.rx_msg_flag    && !st_ff.src_mask[`FB_RX_MSG];
        nxt_st.sle_line = st_ff.mbx_empty_flag && !st_ff.src_mask[`FB_MBX_EMPTY];
    end

    // state register; every mask starts set, the reset flag starts set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff                 <= '0;
            st_ff.phase           <= can_irq_pkg::PH_IDLE;
            st_ff.mbx_mask        <= `MBX_MASK_RST;
            st_ff.src_mask        <= `SRC_MASK_RST & `SRC_WR_BITS;
            st_ff.reset_done_flag <= `FLAG_RST_DONE;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // outputs
    assign prdata                 = st_ff.prdata;
    assign pslverr                = st_ff.pslverr && (st_ff.phase == can_irq_pkg::PH_ACK);
    assign pready                 = (st_ff.phase == can_irq_pkg::PH_ACK);
    assign overrun_irq_line       = st_ff.ovr_line;
    assign error_status_irq_line  = st_ff.ers_line;
    assign rx_message_irq_line    = st_ff.rm_line;
    assign mailbox_empty_irq_line = st_ff.sle_line;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_unread_flag_set: assert property (
        ce && (|unread_status_bits) |=> st_ff.unread_flag
    ) else $error("unread flag missed a set status bit");

    a_unread_flag_clr: assert property (
        ce && (unread_status_bits == 16'h0000) |=> !st_ff.unread_flag
    ) else $error("unread flag stayed with no status bit");

    a_empty_flag_set: assert property (
        ce && (|tx_end_evt) |=> st_ff.mbx_empty_flag
    ) else $error("mailbox empty flag not set on transmit end");

    a_empty_flag_hold: assert property (
        ce && st_ff.mbx_empty_flag && !(wr_flag && pwdata[`FB_MBX_EMPTY]) |=> st_ff.mbx_empty_flag
    ) else $error("mailbox empty flag cleared without a write of one");

    a_src_reserved_rd: assert property (
        ce && acc && !pwrite && (st_ff.phase == can_irq_pkg::PH_IDLE) && (paddr == `OFS_SRC_MASK)
            |=> (prdata[7:5] == 3'h7) && (prdata[3:2] == 2'h3) && !prdata[8]
    ) else $error("reserved source mask bits read wrong");

    a_rx_msg_set: assert property (
        ce && |(rx_edge & ~mask_mbx) |=> st_ff.rx_msg_flag
    ) else $error("receive message flag missed an enabled reception");

    a_rm_line_gate: assert property (
        ce && st_ff.rx_msg_flag && !st_ff.src_mask[`FB_RX_MSG] |=> rx_message_irq_line
    ) else $error("receive message line not raised");

    a_ers_line_map: assert property (
        ce |=> error_status_irq_line == $past((bus_off_flag && !st_ff.src_mask[`FB_BUS_OFF])
                                              || (error_passive_flag && !st_ff.src_mask[`FB_ERR_PASSIVE]))
    ) else $error("error status line does not follow its sources");

    a_mask_write_lat: assert property (
        ce && wr_src && !pwdata[`FB_MBX_EMPTY] && st_ff.mbx_empty_flag ##1 ce |=> mailbox_empty_irq_line
    ) else $error("mask write did not reach the empty line in time");

    a_reset_flag_set: assert property (
        ce && reset_done_set ##1 ce |=> overrun_irq_line
    ) else $error("reset flag did not raise the overrun line");

    a_sle_masked: assert property (
        ce && st_ff.src_mask[`FB_MBX_EMPTY] |=> !mailbox_empty_irq_line
    ) else $error("masked empty flag reached its line");

    a_ovr_overload: assert property (
        ce && overload_frame_flag && !st_ff.src_mask[`FB_OVERLOAD] |=> overrun_irq_line
    ) else $error("overload flag did not reach the overrun line");

    a_ovr_rx_warn: assert property (
        ce && rx_overload_warn_flag && !st_ff.src_mask[`FB_RX_WARN] |=> overrun_irq_line
    ) else $error("receive warning did not reach the overrun line");

    a_ovr_tx_warn: assert property (
        ce && tx_overload_warn_flag && !st_ff.src_mask[`FB_TX_WARN] |=> overrun_irq_line
    ) else $error("transmit warning did not reach the overrun line");

    a_ovr_remote: assert property (
        ce && remote_request_flag && !st_ff.src_mask[`FB_REMOTE_REQ] |=> overrun_irq_line
    ) else $error("remote request did not reach the overrun line");

    a_ovr_bus_act: assert property (
        ce && st_ff.bus_act_flag && !st_ff.src_mask[`FB_BUS_ACT] |=> overrun_irq_line
    ) else $error("bus activity flag did not reach the overrun line");

    a_ovr_unread: assert property (
        ce && st_ff.unread_flag && !st_ff.src_mask[`FB_UNREAD] |=> overrun_irq_line
    ) else $error("unread flag did not reach the overrun line");

    a_ovr_all_masked: assert property (
        ce && !st_ff.reset_done_flag && ((st_ff.src_mask & 16'h9c12) == 16'h9c12) |=> !overrun_irq_line
    ) else $error("overrun line high with every source masked");

    a_src_write_keep: assert property (
        ce && wr_src |=> (st_ff.src_mask & `SRC_WR_BITS) == ($past(pwdata[15:0]) & `SRC_WR_BITS)
    ) else $error("source mask write not stored");

    a_mbx_mask_write: assert property (
        ce && wr_mbx |=> st_ff.mbx_mask == $past(pwdata[15:0])
    ) else $error("mailbox mask write not stored");

    a_rm_masked: assert property (
        ce && st_ff.src_mask[`FB_RX_MSG] |=> !rx_message_irq_line
    ) else $error("masked receive message flag reached its line");

    a_empty_flag_clr: assert property (
        ce && wr_flag && pwdata[`FB_MBX_EMPTY] && !(|tx_end_evt) |=> !st_ff.mbx_empty_flag
    ) else $error("mailbox empty flag not cleared by a write of one");

endmodule : can_irq_flag_mask

`default_nettype wire

// file: can_irq_defines.svh
`ifndef CAN_IRQ_DEFINES_SVH
`define CAN_IRQ_DEFINES_SVH

// register byte offsets on the apb window
`define OFS_FLAG        12'h000
`define OFS_MBX_MASK    12'h004
`define OFS_SRC_MASK    12'h008
`define OFS_UNREAD      12'h00c

// reset values
`define MBX_MASK_RST    16'hffff
`define SRC_MASK_RST    16'hffff
`define FLAG_RST_DONE   1'h1

// source mask layout: writable bits, bits that always read as one
`define SRC_WR_BITS     16'hfe13
`define SRC_ONE_BITS    16'h00ec

// flag register bit positions
`define FB_OVERLOAD     15
`define FB_BUS_OFF      14
`define FB_ERR_PASSIVE  13
`define FB_RX_WARN      12
`define FB_TX_WARN      11
`define FB_REMOTE_REQ   10
`define FB_RX_MSG       9
`define FB_RESET_DONE   8
`define FB_BUS_ACT      4
`define FB_UNREAD       1
`define FB_MBX_EMPTY    0

`endif

// file: can_irq_pkg.sv
`default_nettype none

package can_irq_pkg;

    // apb slave phase, one-hot
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_ACK  = 2'b10
    } apb_phase_type;

    // all state of the flag and mask block
    typedef struct packed {
        apb_phase_type phase;
        logic [31:0]   prdata;
        logic          pslverr;
        logic [15:0]   mbx_mask;
        logic [15:0]   src_mask;
        logic          rx_msg_flag;
        logic          mbx_empty_flag;
        logic          bus_act_flag;
        logic          reset_done_flag;
        logic          unread_flag;
        logic          ovr_line;
        logic          ers_line;
        logic          rm_line;
        logic          sle_line;
    } irq_state_type;

    // all state of the per-mailbox tracker, mailbox order (bit n = mailbox n)
    typedef struct packed {
        logic [15:0] rxc_prev;
        logic [15:0] unread;
        logic [15:0] src_evt;
    } track_state_type;

    // register layout puts mailboxes 7..0 in bits 15..8 and 15..8 in bits 7..0
    function automatic logic [15:0] swap_bytes(input logic [15:0] v);
        swap_bytes = {v[7:0], v[15:8]};
    endfunction : swap_bytes

endpackage : can_irq_pkg

`default_nettype wire

// file: can_mailbox_track.sv
`default_nettype none

module can_mailbox_track (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // mailbox events, mailbox order
    input  wire logic [15:0] tx_end_evt,
    input  wire logic [15:0] rx_arrive,
    input  wire logic [15:0] receive_complete_bits,
    input  wire logic [15:0] mask_mbx,
    input  wire logic [15:0] unread_clr,
    // results, mailbox order
    output logic      [15:0] rx_edge,
    output logic      [15:0] unread_status_bits,
    output logic      [15:0] mailbox_src_evt
);

    can_irq_pkg::track_state_type st_ff;
    can_irq_pkg::track_state_type nxt_st;

    // reception end is the rising edge of the receive-complete bit
    assign rx_edge            = receive_complete_bits & ~st_ff.rxc_prev;
    assign unread_status_bits = st_ff.unread;
    assign mailbox_src_evt    = st_ff.src_evt;

    // next state; a new arrival beats a software clear of the same bit
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.rxc_prev = receive_complete_bits;
        nxt_st.unread   = (st_ff.unread & ~unread_clr) | (rx_arrive & receive_complete_bits);
        nxt_st.src_evt  = (tx_end_evt | rx_edge) & ~mask_mbx;
    end

    // state register, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_unread_set_arrive: assert property (
        ce && |(rx_arrive & receive_complete_bits) |=> |st_ff.unread
    ) else $error("unread status not set on overwrite");

    a_src_gate_mask: assert property (
        ce && |(tx_end_evt & ~mask_mbx) |=> |mailbox_src_evt
    ) else $error("enabled mailbox event produced no source pulse");

    a_src_masked_quiet: assert property (
        ce && (mask_mbx == 16'hffff) |=> (mailbox_src_evt == 16'h0000)
    ) else $error("masked mailbox raised a source pulse");

endmodule : can_mailbox_track

`default_nettype wire

// file: can_host_irq_model.sv
`default_nettype none

module can_host_irq_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // request lines, order overrun, error status, rx message, mailbox empty
    input  wire logic [3:0] irq_lines,
    input  wire logic       ack,
    // sticky record of lines seen high
    output logic      [3:0] seen
);
    // lines are levels; keep them sticky so a short request is not lost before software looks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen <= 4'h0;
        end else if (ack) begin
            seen <= irq_lines;
        end else begin
            seen <= seen | irq_lines;
        end
    end
endmodule : can_host_irq_model

`default_nettype wire

// file: can_interrupt_flag_mask_logic_tb_top.sv
`default_nettype none

module can_interrupt_flag_mask_logic_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] tx_end_evt, rx_arrive, rxc, src_evt, acc;
    logic [5:0]  lvl, nl;
    logic [3:0]  lines, seen;
    logic        bus_act, rst_done, e;
    logic [15:0] m, wm;
    int          err_count, checks_done, rs;

    can_irq_flag_mask DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_end_evt(tx_end_evt), .rx_arrive(rx_arrive), .receive_complete_bits(rxc),
        .overload_frame_flag(lvl[5]), .bus_off_flag(lvl[4]), .error_passive_flag(lvl[3]),
        .rx_overload_warn_flag(lvl[2]), .tx_overload_warn_flag(lvl[1]), .remote_request_flag(lvl[0]),
        .bus_activity_set(bus_act), .reset_done_set(rst_done), .overrun_irq_line(lines[3]),
        .error_status_irq_line(lines[2]), .rx_message_irq_line(lines[1]),
        .mailbox_empty_irq_line(lines[0]), .mailbox_src_evt(src_evt));

    can_host_irq_model host (.pclk(pclk), .presetn(presetn), .irq_lines(lines), .ack(ack), .seen(seen));

    // clock, 5 ns period
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // mailbox n sits at the byte-swapped bit of the mask and unread registers
    function automatic logic [15:0] sw(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction : sw

    // expected lines from flag word and source mask; reset flag bypasses the mask
    function automatic logic [3:0] exp_lines(input logic [15:0] f, input logic [15:0] k);
        logic [15:0] g;
        g = f & ~k;
        return {(|(g & 16'h9c12)) | f[8], |(g & 16'h6000), g[9], g[0]};
    endfunction : exp_lines

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer; holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 1, pready);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask : rdchk

    task automatic lines_chk(input logic [3:0] exp);
        repeat (3) @(posedge pclk);
        chk("lines", exp, lines);
    endtask : lines_chk

    // one-cycle pulse of transmit-end and arrival events, receive-complete bits left at rc, collecting the per-mailbox sources
    task automatic mbx_pulse(input logic [15:0] tx, input logic [15:0] arr, input logic [15:0] rc);
        @(posedge pclk);
        tx_end_evt <= tx; rx_arrive <= arr; rxc <= rc;
        acc = 16'h0;
        @(posedge pclk);
        tx_end_evt <= 16'h0; rx_arrive <= 16'h0;
        repeat (4) begin
            @(posedge pclk);
            acc |= src_evt;
        end
    endtask : mbx_pulse

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // watchdog well above the run length
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        end_of_test();
    end

    initial begin
        {psel, penable, pwrite, ack, bus_act, rst_done} = '0;
        paddr = 12'h0; pwdata = 32'h0; lvl = 6'h0;
        tx_end_evt = 16'h0; rx_arrive = 16'h0; rxc = 16'h0;
        err_count = 0; checks_done = 0;
        presetn = 1'b0;
        rs = $urandom(68);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, unmaskable reset flag, unmapped address
        rdchk("mbx_mask", 12'h004, 32'h0000ffff);
        rdchk("src_mask", 12'h008, 32'h0000feff);
        rdchk("flags", 12'h000, 32'h00000100);
        chk("ovr_rst", 1, lines[3]);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 1, e);
        apb(1'b1, 12'h000, 32'h00000100);
        lines_chk(4'h0);
        $display("test reset done");
        // level flags routed through random and corner source masks
        for (int i = 0; i < 12; i++) begin
            m = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom());
            wm = (m & 16'hfe13) | 16'h00ec;
            apb(1'b1, 12'h008, {16'h0, wm});
            rdchk("src_rb", 12'h008, {16'h0, wm});
            @(posedge pclk);
            // expectation uses the new levels, the nonblocking update is not yet visible here
            nl = (i < 2) ? 6'h3f : 6'($urandom());
            lvl <= nl;
            lines_chk(exp_lines({nl, 10'h0}, wm));
            rdchk("flags_lvl", 12'h000, {16'h0, lvl, 10'h0});
        end
        @(posedge pclk);
        lvl <= 6'h0;
        apb(1'b1, 12'h008, 32'h000000ec);
        lines_chk(4'h0);
        $display("test routing done");
        // mailbox empty: mailbox 3 enabled, 4 masked
        apb(1'b1, 12'h004, {16'h0, sw(~16'h0028)});
        rdchk("mbx_rb", 12'h004, {16'h0, sw(~16'h0028)});
        apb(1'b1, 12'h008, 32'h000000ed);
        mbx_pulse(16'h0018, 16'h0, 16'h0);
        chk("src_tx", 16'h0008, acc);
        lines_chk(4'h0);
        apb(1'b1, 12'h008, 32'h000000ec);
        lines_chk(4'h1);
        chk("host_sle", 1, seen[0]);
        apb(1'b1, 12'h000, 32'h00000000);
        rdchk("empty_hold", 12'h000, 32'h00000001);
        apb(1'b1, 12'h000, 32'h00000001);
        lines_chk(4'h0);
        $display("test mailbox empty done");
        // reception: masked mailbox 6 first, then enabled mailbox 5
        mbx_pulse(16'h0, 16'h0, 16'h0040);
        chk("src_rx6", 16'h0000, acc);
        rdchk("rxmsg_masked", 12'h000, 32'h00000000);
        mbx_pulse(16'h0, 16'h0, 16'h0060);
        chk("src_rx5", 16'h0020, acc);
        lines_chk(4'h2);
        mbx_pulse(16'h0, 16'h0020, 16'h0060);
        rdchk("unread_reg", 12'h00c, {16'h0, sw(16'h0020)});
        lines_chk(4'ha);
        apb(1'b1, 12'h000, 32'h00000002);
        rdchk("unread_hold", 12'h000, 32'h00000202);
        apb(1'b1, 12'h00c, {16'h0, sw(16'h0020)});
        rdchk("unread_clr", 12'h000, 32'h00000200);
        mbx_pulse(16'h0, 16'h0, 16'h0);
        lines_chk(4'h0);
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
        @(posedge pclk);
        chk("host_ack", 4'h0, seen);
        $display("test receive done");
        // bus activity flag, then masked again
        @(posedge pclk);
        bus_act <= 1'b1;
        @(posedge pclk);
        bus_act <= 1'b0;
        lines_chk(4'h8);
        apb(1'b1, 12'h008, 32'h000000fc);
        lines_chk(4'h0);
        apb(1'b1, 12'h000, 32'h00000010);
        rdchk("act_clr", 12'h000, 32'h00000000);
        @(posedge pclk);
        rst_done <= 1'b1;
        @(posedge pclk);
        rst_done <= 1'b0;
        lines_chk(4'h8);
        $display("test activity done");
        end_of_test();
    end
endmodule : can_interrupt_flag_mask_logic_tb_top

`default_nettype wire
